// ---- common/crs_pkg.sv ----
// types for the core register set
package crs_pkg;
  typedef enum logic [3:0] {
    CRS_OP_ADD = 4'h0,
    CRS_OP_ADC = 4'h1,
    CRS_OP_SUB = 4'h2,
    CRS_OP_AND = 4'h3,
    CRS_OP_OR = 4'h4,
    CRS_OP_XOR = 4'h5,
    CRS_OP_MOV = 4'h6,
    CRS_OP_SHL = 4'h7,
    CRS_OP_SHR = 4'h8
  } crs_alu_op_t;
  typedef enum logic [1:0] {
    CRS_DST_A = 2'h0,
    CRS_DST_X = 2'h1,
    CRS_DST_F = 2'h2,
    CRS_DST_SP = 2'h3
  } crs_dst_t;
  typedef enum logic [1:0] {
    CRS_SP_HOLD = 2'h0,
    CRS_SP_INC = 2'h1,
    CRS_SP_DEC = 2'h2,
    CRS_SP_LOAD = 2'h3
  } crs_sp_op_t;
  // one decoded two-byte instruction from the sequencer
  typedef struct packed {
    logic valid;
    logic direct;
    crs_alu_op_t op;
    crs_dst_t dst;
    logic [7:0] operand;
  } crs_instr_t;
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] idx;
    logic [7:0] sp;
    logic [7:0] flags;
    logic [15:0] pc;
  } crs_state_t;
endpackage

// ---- common/crs_regs.svh ----
// constants for the core register set: offsets, fields, reset values, write mask, pc step
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH
`define CRS_FLAGS_ADDR 8'hf7
`define CRS_FLAG_GIE 0
`define CRS_FLAG_ZERO 1
`define CRS_FLAG_CARRY 2
`define CRS_FLAG_SUPER 3
`define CRS_FLAG_BANK 4
`define CRS_FLAGS_RST 8'h02
`define CRS_FLAGS_WMASK 8'h17
`define CRS_DATA_RST 8'h00
`define CRS_PC_RST 16'h0000
`define CRS_PC_STEP 16'h0002
`endif

// ---- design/crs_core_regs.sv ----
// architectural register set of the 8-bit core with source immediate and direct modes
`timescale 1ns/1ps
`include "crs_regs.svh"
////////////////////////////////////////////////////////////////////////////////
module crs_core_regs #(
  parameter int PC_WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire crs_pkg::crs_instr_t instr,
  input wire logic [7:0] src_rdata,
  input wire logic src_rvalid,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic pc_load,
  input wire logic [PC_WIDTH-1:0] pc_target,
  input wire crs_pkg::crs_sp_op_t sp_op,
  input wire logic [7:0] sp_value,
  input wire logic super_enter,
  input wire logic super_leave,
  input wire logic irq_req,
  output logic [7:0] src_addr_q,
  output logic src_rd_q,
  output logic [7:0] reg_rdata_q,
  output logic reg_hit_q,
  output logic irq_take_q,
  output logic bank_sel_q,
  output logic [7:0] pc_high_q,
  output logic [7:0] pc_low_q,
  output logic [7:0] index_q,
  output logic [7:0] sp_q,
  output crs_pkg::crs_state_t state_q
);
  typedef enum logic [0:0] {
    CRS_ST_IDLE = 1'b0,
    CRS_ST_FETCH = 1'b1
  } crs_seq_t;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic shared by both source modes
  function automatic logic [8:0] crs_alu(input crs_pkg::crs_alu_op_t op,
                                         input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    logic [8:0] r;
    r = 9'h000;
    unique case (op)
      crs_pkg::CRS_OP_ADD: r = {1'b0, a} + {1'b0, b};
      crs_pkg::CRS_OP_ADC: r = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      crs_pkg::CRS_OP_SUB: r = {1'b0, a} - {1'b0, b};
      crs_pkg::CRS_OP_AND: r = {1'b0, a & b};
      crs_pkg::CRS_OP_OR: r = {1'b0, a | b};
      crs_pkg::CRS_OP_XOR: r = {1'b0, a ^ b};
      crs_pkg::CRS_OP_MOV: r = {1'b0, b};
      crs_pkg::CRS_OP_SHL: r = {a, 1'b0};
      crs_pkg::CRS_OP_SHR: r = {a[0], 1'b0, a[7:1]};
      default: r = 9'h000;
    endcase
    return r;
  endfunction

  function automatic logic crs_sets_flags(input crs_pkg::crs_alu_op_t op);
    return op != crs_pkg::CRS_OP_MOV;
  endfunction

  function automatic logic [7:0] src_data_sel(input logic [7:0] d);
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  crs_seq_t seq_q;
  crs_pkg::crs_instr_t held_q;
  logic [7:0] acc_q;
  logic [7:0] flags_q;
  logic [PC_WIDTH-1:0] pc_q;
  logic [7:0] src_val;
  logic exec;
  crs_pkg::crs_instr_t cur;
  logic [7:0] dst_val;
  logic [8:0] alu_res;
  logic to_flags;
  logic flag_logic_wr;
  logic flag_alu_wr;

  // a direct operand waits in CRS_ST_FETCH until the memory read returns src_rvalid
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= CRS_ST_IDLE;
      held_q <= '0;
    end else begin
      unique case (seq_q)
        CRS_ST_IDLE: begin
          if (instr.valid && instr.direct) begin
            seq_q <= CRS_ST_FETCH;
            held_q <= instr;
          end
        end
        CRS_ST_FETCH: begin
          if (src_rvalid) begin
            seq_q <= CRS_ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_rd_q <= 1'b0;
      src_addr_q <= `CRS_DATA_RST;
    end else begin
      src_rd_q <= (seq_q == CRS_ST_IDLE) && instr.valid && instr.direct;
      if (seq_q == CRS_ST_IDLE && instr.valid && instr.direct) begin
        src_addr_q <= instr.operand;
      end
    end
  end

  always_comb begin
    if (seq_q == CRS_ST_FETCH) begin
      cur = held_q;
      exec = src_rvalid;
      src_val = src_data_sel(src_rdata);
    end else begin
      cur = instr;
      exec = instr.valid && !instr.direct;
      src_val = instr.operand;
    end
    unique case (cur.dst)
      crs_pkg::CRS_DST_A: dst_val = acc_q;
      crs_pkg::CRS_DST_X: dst_val = index_q;
      crs_pkg::CRS_DST_F: dst_val = flags_q;
      crs_pkg::CRS_DST_SP: dst_val = sp_q;
    endcase
    alu_res = crs_alu(cur.op, dst_val, src_val, flags_q[`CRS_FLAG_CARRY]);
    to_flags = exec && cur.dst == crs_pkg::CRS_DST_F;
    // of writes aimed at F, only OR/AND immediate reach the flags register
    flag_logic_wr = to_flags && !cur.direct &&
                    (cur.op == crs_pkg::CRS_OP_OR || cur.op == crs_pkg::CRS_OP_AND);
    flag_alu_wr = exec && !to_flags && crs_sets_flags(cur.op);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= `CRS_DATA_RST;
    end else if (exec && cur.dst == crs_pkg::CRS_DST_A) begin
      acc_q <= alu_res[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      index_q <= `CRS_DATA_RST;
    end else if (exec && cur.dst == crs_pkg::CRS_DST_X) begin
      index_q <= alu_res[7:0];
    end
  end

  // instruction writes win over the stack sequencer in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= `CRS_DATA_RST;
    end else if (exec && cur.dst == crs_pkg::CRS_DST_SP) begin
      sp_q <= alu_res[7:0];
    end else begin
      unique case (sp_op)
        crs_pkg::CRS_SP_HOLD: sp_q <= sp_q;
        crs_pkg::CRS_SP_INC: sp_q <= sp_q + 8'h01;
        crs_pkg::CRS_SP_DEC: sp_q <= sp_q - 8'h01;
        crs_pkg::CRS_SP_LOAD: sp_q <= sp_value;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= PC_WIDTH'(`CRS_PC_RST);
    end else if (pc_load) begin
      pc_q <= pc_target;
    end else if (exec) begin
      pc_q <= pc_q + PC_WIDTH'(`CRS_PC_STEP);
    end
  end

  crs_flag_reg u_flags (
    .clock(clock),
    .rst_n(rst_n),
    .logic_wr(flag_logic_wr),
    .logic_val(alu_res[7:0]),
    .alu_wr(flag_alu_wr),
    .alu_zero(alu_res[7:0] == 8'h00),
    .alu_carry(alu_res[8]),
    .super_set(super_enter),
    .super_clr(super_leave),
    .flags_q(flags_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register space sees only the flags, nothing else of the core
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
      reg_hit_q <= 1'b0;
    end else begin
      reg_hit_q <= reg_rd && reg_addr == `CRS_FLAGS_ADDR;
      reg_rdata_q <= (reg_rd && reg_addr == `CRS_FLAGS_ADDR) ? flags_q : 8'h00;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_take_q <= 1'b0;
      bank_sel_q <= 1'b0;
      pc_high_q <= 8'h00;
      pc_low_q <= 8'h00;
      state_q <= '0;
    end else begin
      irq_take_q <= irq_req && flags_q[`CRS_FLAG_GIE];
      bank_sel_q <= flags_q[`CRS_FLAG_BANK];
      pc_high_q <= 8'(pc_q >> 8);
      pc_low_q <= pc_q[7:0];
      state_q <= '{acc: acc_q, idx: index_q, sp: sp_q, flags: flags_q,
                   pc: 16'(pc_q)};
    end
  end
endmodule

// ---- design/crs_flag_reg.sv ----
// flags register with masked logical update and supervisor-only bit
`timescale 1ns/1ps
`include "crs_regs.svh"
module crs_flag_reg (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic logic_wr,
  input wire logic [7:0] logic_val,
  input wire logic alu_wr,
  input wire logic alu_zero,
  input wire logic alu_carry,
  input wire logic super_set,
  input wire logic super_clr,
  output logic [7:0] flags_q
);
  logic [7:0] flags_d;
  always_comb begin
    flags_d = flags_q;
    if (logic_wr) begin
      // super bit and reserved bits keep their value
      flags_d = (logic_val & `CRS_FLAGS_WMASK) | (flags_q & ~`CRS_FLAGS_WMASK);
    end else if (alu_wr) begin
      flags_d[`CRS_FLAG_ZERO] = alu_zero;
      flags_d[`CRS_FLAG_CARRY] = alu_carry;
    end
    if (super_set) begin
      flags_d[`CRS_FLAG_SUPER] = 1'b1;
    end else if (super_clr) begin
      flags_d[`CRS_FLAG_SUPER] = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= `CRS_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule

// ---- dv/crs_core_regs_chk.sv ----
// port checker for the core register set
`timescale 1ns/1ps
`include "crs_regs.svh"
module crs_core_regs_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire crs_pkg::crs_instr_t instr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic super_enter,
  input wire logic irq_req,
  input wire logic [7:0] src_addr_q,
  input wire logic src_rd_q,
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_hit_q,
  input wire logic irq_take_q,
  input wire logic bank_sel_q,
  input wire logic [7:0] pc_high_q,
  input wire logic [7:0] pc_low_q,
  input wire crs_pkg::crs_state_t state_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  AST_FLAG_HIT: assert property (reg_rd && reg_addr == `CRS_FLAGS_ADDR |=> reg_hit_q)
    else $error("flags read not answered");
  AST_OTHER_MISS: assert property (reg_rd && reg_addr != `CRS_FLAGS_ADDR
    |=> !reg_hit_q && reg_rdata_q == 8'h00) else $error("core register seen in space");
  AST_BANK: assert property (bank_sel_q == state_q.flags[`CRS_FLAG_BANK])
    else $error("bank select differs from flags");
  AST_PC_SPLIT: assert property ({pc_high_q, pc_low_q} == state_q.pc)
    else $error("pc bytes differ from pc");
  AST_IRQ_GATE: assert property (irq_take_q == ($past(irq_req) && state_q.flags[0]))
    else $error("interrupt not gated by enable");
  AST_SUPER_SET: assert property (super_enter |-> ##2 state_q.flags[`CRS_FLAG_SUPER])
    else $error("supervisor bit not set");
  AST_IMM_MOV_A: assert property (instr.valid && !instr.direct
    && instr.op == crs_pkg::CRS_OP_MOV && instr.dst == crs_pkg::CRS_DST_A
    |-> ##2 state_q.acc == $past(instr.operand, 2)) else $error("immediate move lost");
  AST_SRC_RD: assert property (instr.valid && instr.direct
    |=> src_rd_q && src_addr_q == $past(instr.operand) ##1 !src_rd_q)
    else $error("direct source read wrong");
  cover property (reg_hit_q);
  cover property (src_rd_q);
  cover property (irq_take_q);
endmodule
bind crs_core_regs crs_core_regs_chk u_chk (.clock(clock), .rst_n(rst_n), .instr(instr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .super_enter(super_enter), .irq_req(irq_req),
  .src_addr_q(src_addr_q), .src_rd_q(src_rd_q), .reg_rdata_q(reg_rdata_q),
  .reg_hit_q(reg_hit_q), .irq_take_q(irq_take_q), .bank_sel_q(bank_sel_q),
  .pc_high_q(pc_high_q), .pc_low_q(pc_low_q), .state_q(state_q));

// ---- dv/crs_mem_model.sv ----
// data memory answering direct-mode reads after lat cycles
`timescale 1ns/1ps
module crs_mem_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rd,
  input wire logic [7:0] addr,
  input wire logic [3:0] lat,
  output logic [7:0] rdata,
  output logic rvalid
);
  logic [7:0] addr_q;
  logic [3:0] cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      addr_q <= 8'h00;
      rvalid <= 1'b0;
      rdata <= 8'h00;
    end else if (rd) begin
      cnt_q <= lat;
      addr_q <= addr;
      rvalid <= 1'b0;
      rdata <= ~rdata;
    end else if (cnt_q == 4'h1) begin
      cnt_q <= 4'h0;
      rvalid <= 1'b1;
      rdata <= addr_q ^ 8'ha5;
    end else begin
      // idle data toggles so a stale byte is never mistaken for an answer
      cnt_q <= (cnt_q == 4'h0) ? 4'h0 : cnt_q - 4'h1;
      rvalid <= 1'b0;
      rdata <= ~rdata;
    end
  end
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the core register set
`timescale 1ns/1ps
`include "crs_regs.svh"
module tb_top;
  logic clock, rst_n, src_rvalid, reg_rd, pc_load, super_enter, super_leave, irq_req;
  logic src_rd_q, reg_hit_q, irq_take_q, bank_sel_q;
  logic [7:0] src_rdata, reg_addr, sp_value, src_addr_q, reg_rdata_q;
  logic [7:0] pc_high_q, pc_low_q, index_q, sp_q;
  logic [15:0] pc_target, pc;
  logic [3:0] lat;
  crs_pkg::crs_instr_t instr;
  crs_pkg::crs_sp_op_t sp_op;
  crs_pkg::crs_state_t state_q;
  int checks, n_fail, cyc;
  crs_core_regs dut (.clock(clock), .rst_n(rst_n), .instr(instr), .src_rdata(src_rdata),
    .src_rvalid(src_rvalid), .reg_rd(reg_rd), .reg_addr(reg_addr), .pc_load(pc_load),
    .pc_target(pc_target), .sp_op(sp_op), .sp_value(sp_value), .super_enter(super_enter),
    .super_leave(super_leave), .irq_req(irq_req), .src_addr_q(src_addr_q),
    .src_rd_q(src_rd_q), .reg_rdata_q(reg_rdata_q), .reg_hit_q(reg_hit_q),
    .irq_take_q(irq_take_q), .bank_sel_q(bank_sel_q), .pc_high_q(pc_high_q),
    .pc_low_q(pc_low_q), .index_q(index_q), .sp_q(sp_q), .state_q(state_q));
  crs_mem_model mem (.clock(clock), .rst_n(rst_n), .rd(src_rd_q), .addr(src_addr_q),
    .lat(lat), .rdata(src_rdata), .rvalid(src_rvalid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one instruction; results read once the state snapshot has caught up
  task automatic exec(input logic d, input crs_pkg::crs_alu_op_t op,
                      input crs_pkg::crs_dst_t dst, input logic [7:0] v);
    int i;
    instr <= '{1'b1, d, op, dst, v};
    @(posedge clock);
    instr <= '0;
    i = 0;
    while (d && src_rvalid !== 1'b1 && i < 20) begin
      @(posedge clock);
      i++;
    end
    // a read that never answers counts against the run
    if (d && i == 20) begin
      n_fail++;
    end
    repeat (2) @(posedge clock);
    pc = pc + `CRS_PC_STEP;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] d, input logic h);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    chk(reg_hit_q, h, "hit");
    chk(reg_rdata_q, d, "rdata");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_n, reg_rd, pc_load, super_enter, super_leave, irq_req} = '0;
    {reg_addr, sp_value, pc_target, pc} = '0;
    instr = '0;
    sp_op = crs_pkg::CRS_SP_HOLD;
    lat = 4'h1;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    chk(state_q.flags, `CRS_FLAGS_RST, "reset flags");
    chk(state_q[47:24], 32'h00000000, "reset acc idx sp");
    chk(state_q.pc, `CRS_PC_RST, "reset pc");
    exec(1'b0, crs_pkg::CRS_OP_MOV, crs_pkg::CRS_DST_A, 8'hff);
    exec(1'b0, crs_pkg::CRS_OP_ADD, crs_pkg::CRS_DST_A, 8'h01);
    chk(state_q.acc, 8'h00, "acc");
    chk(state_q.flags, 8'h06, "flags");
    chk({pc_high_q, pc_low_q}, pc, "pc");
    $display("test alu done");
    irq_req <= 1'b1;
    exec(1'b0, crs_pkg::CRS_OP_OR, crs_pkg::CRS_DST_F, 8'hff);
    chk(state_q.flags, 8'h17, "flags");
    chk(bank_sel_q, 1'b1, "bank");
    chk(irq_take_q, 1'b1, "irq");
    exec(1'b0, crs_pkg::CRS_OP_MOV, crs_pkg::CRS_DST_F, 8'h00);
    chk(state_q.flags, 8'h17, "flags");
    exec(1'b0, crs_pkg::CRS_OP_AND, crs_pkg::CRS_DST_F, 8'h00);
    chk(state_q.flags, 8'h00, "flags");
    chk(irq_take_q, 1'b0, "irq");
    super_enter <= 1'b1;
    @(posedge clock);
    super_enter <= 1'b0;
    rd_reg(`CRS_FLAGS_ADDR, 8'h08, 1'b1);
    rd_reg(8'hf6, 8'h00, 1'b0);
    super_leave <= 1'b1;
    @(posedge clock);
    super_leave <= 1'b0;
    rd_reg(`CRS_FLAGS_ADDR, 8'h00, 1'b1);
    $display("test flags done");
    exec(1'b1, crs_pkg::CRS_OP_SUB, crs_pkg::CRS_DST_A, 8'h10);
    chk(state_q.acc, 8'h4b, "acc");
    chk(state_q.flags, 8'h04, "flags");
    lat <= 4'h5;
    exec(1'b1, crs_pkg::CRS_OP_MOV, crs_pkg::CRS_DST_X, 8'h20);
    chk(index_q, 8'h85, "index");
    chk({pc_high_q, pc_low_q}, pc, "pc");
    $display("test direct done");
    exec(1'b0, crs_pkg::CRS_OP_MOV, crs_pkg::CRS_DST_SP, 8'h40);
    chk(sp_q, 8'h40, "sp");
    sp_op <= crs_pkg::CRS_SP_INC;
    @(posedge clock);
    sp_op <= crs_pkg::CRS_SP_HOLD;
    repeat (2) @(posedge clock);
    chk(sp_q, 8'h41, "sp");
    pc_load <= 1'b1;
    pc_target <= 16'h1ffe;
    @(posedge clock);
    pc_load <= 1'b0;
    repeat (2) @(posedge clock);
    chk({pc_high_q, pc_low_q}, 16'h1ffe, "pc");
    $display("test stack and pc done");
    exec(1'b0, crs_pkg::CRS_OP_ADC, crs_pkg::CRS_DST_A, 8'h34);
    chk(state_q.acc, 8'h80, "acc");
    chk(state_q.flags, 8'h00, "flags");
    exec(1'b0, crs_pkg::CRS_OP_SHL, crs_pkg::CRS_DST_A, 8'h00);
    chk(state_q.acc, 8'h00, "acc");
    chk(state_q.flags, 8'h06, "flags");
    exec(1'b0, crs_pkg::CRS_OP_XOR, crs_pkg::CRS_DST_A, 8'h81);
    chk(state_q.flags, 8'h00, "flags");
    exec(1'b0, crs_pkg::CRS_OP_SHR, crs_pkg::CRS_DST_A, 8'h00);
    chk(state_q.acc, 8'h40, "acc");
    chk(state_q.flags, 8'h04, "flags");
    $display("test shift and logic done");
    tally_and_finish();
  end
endmodule
